// ==== hdl/upc_pkg.sv ====
// Package: register map, field positions and carrier types for the USB status/PHY control block
package upc_pkg;
	localparam logic [7:0] OFS_PID = 8'h2C;
	localparam logic [7:0] OFS_EP = 8'h30;
	localparam logic [7:0] OFS_EP_MASK = 8'h34;
	localparam logic [7:0] OFS_OTG_MASK = 8'h38;
	localparam logic [7:0] OFS_PWR = 8'h3C;
	localparam logic [7:0] OFS_PHY = 8'h40;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h44;
	localparam logic [7:0] OFS_IRQ_EN = 8'h48;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h4C;
	localparam logic [7:0] OFS_LINE = 8'h50;
	localparam int EP_VALID_BIT = 4;
	localparam int PWR_VALID_BIT = 8;
	localparam int PHY_PD_DIS_BIT = 18;
	localparam int PHY_SE0_BIT = 13;
	localparam int PHY_K_BIT = 12;
	localparam int PHY_FILT_LO = 8;
	localparam int PHY_AUTO_BIT = 7;
	localparam int PHY_CFG_LO = 4;
	localparam int IRQ_PKT = 0;
	localparam int IRQ_SE0 = 1;
	localparam int IRQ_K = 2;
	localparam int IRQ_LINE = 3;
	localparam int IRQ_W = 4;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [4:0] EP_SPECIAL = 5'h10;

	typedef struct packed {
		logic valid;
		logic [3:0] pid;
		logic [3:0] ep;
		logic ep_valid;
	} upc_pkt_t;

	typedef struct packed {
		logic [2:0] cfg_pins;
		logic port_eight_a_pd_en;
		logic port_eight_b_pd_en;
	} upc_xcvr_t;

	typedef enum logic [0:0] {
		ST_AWAKE = 1'b0,
		ST_SUSP = 1'b1
	} upc_state_t;
endpackage : upc_pkg

// ==== hdl/upc_regs.sv ====
// Module: packet capture, endpoint marking, line filter and PHY control registers over APB
// What this block does
// R1 - The last received packet identifier is captured into a read-only field reset to zero.
// R2 - The last received endpoint number is copied into bits 3:0 of the endpoint register.
// R3 - Bit 4 of the endpoint register flags that the captured endpoint is meaningful.
// R4 - A 16-bit mask marks endpoints whose value on the receive port is ORed with 0x10.
// R5 - Bit 18 of the PHY control register set to 1 turns off the pulldowns of both ports.
// R6 - After an automatic resume caused by SE0, bit 13 is set until software writes 0.
// R7 - After an automatic resume caused by K, bit 12 is set until software writes 0.
// R8 - A line state change is forwarded only after 2 to the power of bits 11:8 cycles.
// R9 - Bit 7 lets the suspend controller resume by itself, else software polls the line.
// R10 - Bits 6:4 of the PHY control register drive the three transceiver config pins.
// R11 - The power signalling register holds a valid bit 8 and a data byte 7:0.
// R12 - Reserved bits read as zero and ignore writes.
`timescale 1ns/1ps
module upc_regs
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoded packets from the receive logic
	input wire upc_pkg::upc_pkt_t pkt,
	// Receive port endpoint
	output logic [4:0] rx_ep_data,
	output logic rx_ep_stb,
	// Transceiver
	input wire logic [1:0] line_state_pin,
	output logic [1:0] line_state_filt,
	output upc_pkg::upc_xcvr_t xcvr,
	// Suspend control
	input wire logic suspend_req,
	input wire logic wake_req,
	output logic suspended,
	output logic auto_resume,
	// Plain register outputs
	output logic [31:0] otg_flag_mask,
	output logic [8:0] power_signal,
	// Interrupt
	output logic irq
);
	logic [3:0] pid_r;
	logic [4:0] ep_r;
	logic [15:0] ep_mask_r;
	logic [31:0] otg_mask_r;
	logic [8:0] pwr_r;
	logic pd_dis_r, se0_r, k_r, auto_en_r;
	logic [3:0] filt_log_r;
	logic [2:0] cfg_r;
	logic [upc_pkg::IRQ_W-1:0] stat_r, en_r;
	logic [1:0] ls_s1_r, ls_s2_r, cand_r, filt_r;
	logic [15:0] cnt_r;
	logic [4:0] rx_ep_r;
	logic rx_stb_r, resume_r;
	logic [31:0] rdata_r;
	logic err_r;
	upc_pkg::upc_state_t state_r, state_nxt;

	// Address decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire hit_pid = paddr == upc_pkg::OFS_PID;
	wire hit_ep = paddr == upc_pkg::OFS_EP;
	wire hit_mask = paddr == upc_pkg::OFS_EP_MASK;
	wire hit_otg = paddr == upc_pkg::OFS_OTG_MASK;
	wire hit_pwr = paddr == upc_pkg::OFS_PWR;
	wire hit_phy = paddr == upc_pkg::OFS_PHY;
	wire hit_stat = paddr == upc_pkg::OFS_IRQ_STAT;
	wire hit_en = paddr == upc_pkg::OFS_IRQ_EN;
	wire hit_clr = paddr == upc_pkg::OFS_IRQ_CLR;
	wire hit_line = paddr == upc_pkg::OFS_LINE;
	wire mapped = hit_pid | hit_ep | hit_mask | hit_otg | hit_pwr | hit_phy | hit_stat
		| hit_en | hit_clr | hit_line;
	wire wr = access & pwrite & mapped;
	wire wr_mask = wr & hit_mask;
	wire wr_otg = wr & hit_otg;
	wire wr_pwr = wr & hit_pwr;
	wire wr_phy = wr & hit_phy;
	wire wr_en = wr & hit_en;
	wire wr_clr = wr & hit_clr;

	// Read words; unnamed bits stay zero [R12]
	wire [31:0] phy_word = {13'h0000, pd_dis_r, 4'h0, se0_r, k_r, filt_log_r, auto_en_r,
		cfg_r, 4'h0};
	wire [31:0] rd_mux =
		hit_pid ? {28'h0000000, pid_r} :
		hit_ep ? {27'h0000000, ep_r} :
		hit_mask ? {16'h0000, ep_mask_r} :
		hit_otg ? otg_mask_r :
		hit_pwr ? {23'h000000, pwr_r} :
		hit_phy ? phy_word :
		hit_stat ? {28'h0000000, stat_r} :
		hit_en ? {28'h0000000, en_r} :
		hit_line ? {29'h00000000, suspended, filt_r} :
		32'h0000_0000;

	// Read data sampled in setup so it comes from a flop during access
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_r <= upc_pkg::RST_ZERO;
			err_r <= 1'b0;
		end
		else if (setup)
		begin
			rdata_r <= pwrite ? upc_pkg::RST_ZERO : rd_mux;
			err_r <= ~mapped;
		end
	end
	assign prdata = rdata_r;
	assign pslverr = access & err_r;
	assign pready = access;

	// Packet capture and receive port marking
	wire special = ep_mask_r[pkt.ep];
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pid_r <= 4'h0;
			ep_r <= 5'h00;
			rx_ep_r <= 5'h00;
			rx_stb_r <= 1'b0;
		end
		else
		begin
			rx_stb_r <= pkt.valid;
			if (pkt.valid)
			begin
				pid_r <= pkt.pid; // [R1]
				ep_r <= {pkt.ep_valid, pkt.ep}; // [R2] [R3]
				rx_ep_r <= {1'b0, pkt.ep} | (special ? upc_pkg::EP_SPECIAL : 5'h00); // [R4]
			end
		end
	end
	assign rx_ep_data = rx_ep_r;
	assign rx_ep_stb = rx_stb_r;

	// Writable registers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ep_mask_r <= 16'h0000;
			otg_mask_r <= upc_pkg::RST_ZERO;
			pwr_r <= 9'h000;
			pd_dis_r <= 1'b0;
			filt_log_r <= 4'h0;
			auto_en_r <= 1'b0;
			cfg_r <= 3'h0;
			en_r <= 4'h0;
		end
		else
		begin
			if (wr_mask)
				ep_mask_r <= pwdata[15:0]; // [R4]
			if (wr_otg)
				otg_mask_r <= pwdata;
			if (wr_pwr)
				pwr_r <= pwdata[upc_pkg::PWR_VALID_BIT:0]; // [R11]
			if (wr_en)
				en_r <= pwdata[upc_pkg::IRQ_W-1:0];
			if (wr_phy)
			begin
				pd_dis_r <= pwdata[upc_pkg::PHY_PD_DIS_BIT]; // [R5]
				filt_log_r <= pwdata[upc_pkg::PHY_FILT_LO +: 4];
				auto_en_r <= pwdata[upc_pkg::PHY_AUTO_BIT];
				cfg_r <= pwdata[upc_pkg::PHY_CFG_LO +: 3]; // [R10]
			end
		end
	end
	assign otg_flag_mask = otg_mask_r;
	assign power_signal = pwr_r;
	assign xcvr = {cfg_r, ~pd_dis_r, ~pd_dis_r}; // [R5] [R10]

	// Line state filter; restarts whenever the input moves again
	// Shortening the length mid-count lets the counter run on to its wrap
	wire [15:0] limit = (16'h0001 << filt_log_r) - 16'h0001;
	wire ls_moved = ls_s2_r != cand_r;
	wire ls_pend = cand_r != filt_r;
	wire ls_take = ~ls_moved & ls_pend & (cnt_r == limit);
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ls_s1_r <= 2'h0;
			ls_s2_r <= 2'h0;
			cand_r <= 2'h0;
			filt_r <= 2'h0;
			cnt_r <= 16'h0000;
		end
		else
		begin
			ls_s1_r <= line_state_pin;
			ls_s2_r <= ls_s1_r;
			if (ls_moved)
			begin
				cand_r <= ls_s2_r;
				cnt_r <= 16'h0000;
			end
			else if (ls_take)
			begin
				filt_r <= cand_r; // [R8]
				cnt_r <= 16'h0000;
			end
			else if (ls_pend)
				cnt_r <= cnt_r + 16'h0001; // [R8]
		end
	end
	assign line_state_filt = filt_r;

	// Suspend controller
	wire auto_se0 = (state_r == upc_pkg::ST_SUSP) & auto_en_r & (filt_r == upc_pkg::LS_SE0);
	wire auto_k = (state_r == upc_pkg::ST_SUSP) & auto_en_r & (filt_r == upc_pkg::LS_K);
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			upc_pkg::ST_AWAKE:
				if (suspend_req)
					state_nxt = upc_pkg::ST_SUSP;
			upc_pkg::ST_SUSP:
				if (auto_se0 | auto_k | wake_req) // [R9]
					state_nxt = upc_pkg::ST_AWAKE;
			default:
				state_nxt = upc_pkg::ST_AWAKE;
		endcase
	end

	// Cause flags: a hardware set beats a software clear in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= upc_pkg::ST_AWAKE;
			se0_r <= 1'b0;
			k_r <= 1'b0;
			resume_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			resume_r <= auto_se0 | auto_k;
			se0_r <= auto_se0 | (se0_r & ~(wr_phy & ~pwdata[upc_pkg::PHY_SE0_BIT])); // [R6]
			k_r <= auto_k | (k_r & ~(wr_phy & ~pwdata[upc_pkg::PHY_K_BIT])); // [R7]
		end
	end
	assign suspended = state_r == upc_pkg::ST_SUSP;
	assign auto_resume = resume_r;

	// Interrupt status, sticky until cleared by writing 1
	wire [upc_pkg::IRQ_W-1:0] ev = {ls_take, auto_k, auto_se0, pkt.valid};
	wire [upc_pkg::IRQ_W-1:0] clr = wr_clr ? pwdata[upc_pkg::IRQ_W-1:0] : 4'h0;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			stat_r <= 4'h0;
		else
			stat_r <= ev | (stat_r & ~clr);
	end
	assign irq = |(stat_r & en_r);

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_pid_capture: assert property (pkt.valid |=> pid_r == $past(pkt.pid)) // [R1]
		else $error("pid not captured");
	a_ep_capture: assert property (pkt.valid |=> ep_r[3:0] == $past(pkt.ep)) // [R2]
		else $error("endpoint not captured");
	a_ep_valid_flag: assert property (pkt.valid |=> ep_r[4] == $past(pkt.ep_valid)) // [R3]
		else $error("endpoint valid flag wrong");
	a_rx_special_mark: assert property (pkt.valid |=> // [R4]
		rx_ep_stb && rx_ep_data[4] == $past(special) && rx_ep_data[3:0] == $past(pkt.ep))
		else $error("receive port marking wrong");
	a_pulldown_off: assert property (wr_phy && pwdata[upc_pkg::PHY_PD_DIS_BIT] |=> // [R5]
		!xcvr.port_eight_a_pd_en && !xcvr.port_eight_b_pd_en)
		else $error("pulldowns not disabled");
	a_se0_resume: assert property (auto_se0 |=> se0_r && !suspended && auto_resume) // [R6]
		else $error("se0 resume not flagged");
	a_k_resume: assert property (auto_k |=> k_r && !suspended && auto_resume) // [R7]
		else $error("K resume not flagged");
	a_k_clear: assert property (k_r && wr_phy && !pwdata[12] && !auto_k |=> !k_r) // [R7]
		else $error("K flag not cleared");
	a_filter_delay: assert property ($changed(line_state_filt) |-> // [R8]
		$past(cnt_r) == $past(limit))
		else $error("line state passed early");
	a_no_auto_hold: assert property (suspended && !auto_en_r && !wake_req |=> suspended) // [R9]
		else $error("left suspend without auto");
	a_cfg_pins: assert property (wr_phy |=> xcvr.cfg_pins == $past(pwdata[6:4])) // [R10]
		else $error("config pins wrong");
	a_rsv_zero: assert property (setup && hit_phy && !pwrite |=> // [R12]
		prdata[31:19] == 13'h0 && prdata[17:14] == 4'h0 && prdata[3:0] == 4'h0)
		else $error("reserved bits not zero");
endmodule : upc_regs

// ==== testbench/tb_upc_regs.sv ====
// Self-checking bench for the status and transceiver control registers
`timescale 1ns/1ps
module tb_upc_regs;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic suspend_req = 1'b0;
	logic wake_req = 1'b0;
	logic send = 1'b0;
	logic [7:0] pid_ep = 8'h00;
	logic [1:0] ls = 2'h1;
	logic [31:0] prdata, otg_flag_mask, r, seed;
	logic pready, pslverr, rx_ep_stb, suspended, auto_resume, irq, err;
	logic [4:0] rx_ep_data;
	logic [1:0] line_state_pin, line_state_filt;
	logic [8:0] power_signal;
	logic [15:0] m;
	upc_pkg::upc_pkt_t pkt;
	upc_pkg::upc_xcvr_t xcvr;
	int miscompares = 0;
	int total_checks = 0;
	int n;

	always #2.5 clk = ~clk;

	upc_regs i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pkt, .rx_ep_data, .rx_ep_stb, .line_state_pin, .line_state_filt, .xcvr,
		.suspend_req, .wake_req, .suspended, .auto_resume, .otg_flag_mask, .power_signal, .irq);
	upc_far_model i_far (.clk, .send, .pid_ep, .ls, .pkt, .line_state_pin);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic results;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Starts one edge late so back-to-back calls never drive psel twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			miscompares++;
			results();
		end
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask : rd

	task automatic wt(input int sel);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (n < 60 && (sel == 0 ? rx_ep_stb : sel == 1 ? auto_resume
			: line_state_filt == ls) !== 1'b1);
		if (n == 60)
		begin
			miscompares++;
			results();
		end
	endtask : wt

	initial
	begin
		seed = 32'hA6CD;
		repeat (5) @(posedge clk);
		chk({27'h0, xcvr}, 32'h3);
		rstn <= 1'b1;
		for (int a = 'h2C; a <= 'h40; a += 4)
			rd(a[7:0], 32'h0);
		apb(1'b1, upc_pkg::OFS_PHY, 32'hFFFF_FFFF);
		rd(upc_pkg::OFS_PHY, 32'h0004_0FF0);
		chk({27'h0, xcvr}, 32'h1C);
		apb(1'b1, upc_pkg::OFS_PHY, 32'h300);
		ls <= 2'h3;
		wt(2);
		chk(n >= 8 && n <= 16, 1'b1);
		ls <= 2'h1;
		wt(2);
		rd(upc_pkg::OFS_IRQ_STAT, 32'h8);
		chk(irq, 1'b0);
		apb(1'b1, upc_pkg::OFS_IRQ_CLR, 32'hF);
		rd(upc_pkg::OFS_IRQ_STAT, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, upc_pkg::OFS_PHY, 32'h180);
			apb(1'b1, upc_pkg::OFS_IRQ_EN, 32'h1 << (i + 1));
			suspend_req <= 1'b1;
			@(posedge clk);
			suspend_req <= 1'b0;
			@(posedge clk);
			chk(suspended, 1'b1);
			ls <= i ? upc_pkg::LS_K : upc_pkg::LS_SE0;
			wt(1);
			chk(suspended, 1'b0);
			rd(upc_pkg::OFS_PHY, 32'h180 | (32'h1 << (13 - i)));
			chk(irq, 1'b1);
			apb(1'b1, upc_pkg::OFS_PHY, 32'h180);
			rd(upc_pkg::OFS_PHY, 32'h180);
			apb(1'b1, upc_pkg::OFS_IRQ_CLR, 32'hF);
			@(posedge clk);
			chk(irq, 1'b0);
			ls <= 2'h1;
			wt(2);
		end
		apb(1'b1, upc_pkg::OFS_PHY, 32'h100);
		suspend_req <= 1'b1;
		@(posedge clk);
		suspend_req <= 1'b0;
		@(posedge clk);
		ls <= upc_pkg::LS_K;
		wt(2);
		chk(suspended, 1'b1);
		rd(upc_pkg::OFS_LINE, {29'h0, 1'b1, upc_pkg::LS_K});
		wake_req <= 1'b1;
		@(posedge clk);
		wake_req <= 1'b0;
		@(posedge clk);
		chk(suspended, 1'b0);
		rd(upc_pkg::OFS_PHY, 32'h100);
		ls <= 2'h1;
		wt(2);
		apb(1'b1, upc_pkg::OFS_IRQ_CLR, 32'hF);
		seed = lfsr(seed);
		m = seed[15:0];
		apb(1'b1, upc_pkg::OFS_EP_MASK, seed);
		rd(upc_pkg::OFS_EP_MASK, {16'h0, m});
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			pid_ep <= i == 0 ? 8'h50 : i == 1 ? 8'hAF : seed[7:0];
			send <= 1'b1;
			@(posedge clk);
			send <= 1'b0;
			wt(0);
			chk(rx_ep_data, {m[pid_ep[3:0]], pid_ep[3:0]});
			rd(upc_pkg::OFS_PID, {28'h0, pid_ep[7:4]});
			rd(upc_pkg::OFS_EP, {27'h0, pid_ep[5:4] == 2'b01, pid_ep[3:0]});
		end
		rd(upc_pkg::OFS_IRQ_STAT, 32'h1);
		apb(1'b1, upc_pkg::OFS_PID, 32'hF);
		rd(upc_pkg::OFS_PID, {28'h0, pid_ep[7:4]});
		seed = lfsr(seed);
		apb(1'b1, upc_pkg::OFS_OTG_MASK, seed);
		rd(upc_pkg::OFS_OTG_MASK, seed);
		chk(otg_flag_mask, seed);
		apb(1'b1, upc_pkg::OFS_PWR, 32'hFFFF_FFFF);
		rd(upc_pkg::OFS_PWR, 32'h1FF);
		chk(power_signal, 32'h1FF);
		apb(1'b1, upc_pkg::OFS_PHY, 32'h0004_0070);
		@(posedge clk);
		chk({27'h0, xcvr}, 32'h1C);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk({27'h0, xcvr}, 32'h3);
		rstn <= 1'b1;
		rd(upc_pkg::OFS_PHY, 32'h0);
		rd(upc_pkg::OFS_PWR, 32'h0);
		rd(upc_pkg::OFS_EP, 32'h0);
		rd(8'h80, 32'h0);
		chk(err, 1'b1);
		results();
	end
endmodule : tb_upc_regs

// ==== testbench/upc_far_model.sv ====
// Model of the receive logic and the transceiver line facing the block
`timescale 1ns/1ps
module upc_far_model
(
	// Clock
	input wire logic clk,
	// Bench commands
	input wire logic send,
	input wire logic [7:0] pid_ep,
	input wire logic [1:0] ls,
	// Towards the block
	output upc_pkg::upc_pkt_t pkt,
	output logic [1:0] line_state_pin
);
	// Idle pid and ep fields show the inverse so stale values never look valid
	always_ff @(posedge clk)
	begin
		pkt.valid <= send;
		// Only token packets carry a meaningful endpoint
		pkt.ep_valid <= send & (pid_ep[5:4] == 2'b01);
		pkt.pid <= send ? pid_ep[7:4] : ~pid_ep[7:4];
		pkt.ep <= send ? pid_ep[3:0] : ~pid_ep[3:0];
		line_state_pin <= ls;
	end
endmodule : upc_far_model
